// ---- rtl/scrl_pkg.sv ----
// Purpose: shared constants and types for the serial clock recovery loop
// Assumes: APB slave with 32-bit data, one word per register
// Notes: the oversampling rate is a one-cycle tick derived from ref_clk
package scrl_pkg;
  // register byte offsets
  localparam logic [7:0] SCRL_OFS_CMD = 8'h00;
  localparam logic [7:0] SCRL_OFS_DIV = 8'h04;
  localparam logic [7:0] SCRL_OFS_STATUS = 8'h08;
  localparam logic [7:0] SCRL_OFS_CODING = 8'h0C;
  // command field position in the loop_command_reg word
  localparam int SCRL_CMD_LSB = 5;
  localparam int SCRL_CMD_MSB = 7;
  // command codes
  localparam logic [2:0] SCRL_CMD_NULL = 3'h0;
  localparam logic [2:0] SCRL_CMD_SEARCH = 3'h1;
  localparam logic [2:0] SCRL_CMD_CLR_MISS = 3'h2;
  localparam logic [2:0] SCRL_CMD_DISABLE = 3'h3;
  localparam logic [2:0] SCRL_CMD_SRC_GEN = 3'h4;
  localparam logic [2:0] SCRL_CMD_SRC_PIN = 3'h5;
  localparam logic [2:0] SCRL_CMD_FM = 3'h6;
  localparam logic [2:0] SCRL_CMD_NRZI = 3'h7;
  // reset values and divisor minimum
  localparam logic [15:0] SCRL_DIV_RESET = 16'h0002;
  localparam logic [15:0] SCRL_DIV_MIN = 16'h0002;
  localparam logic [1:0] SCRL_CODING_RESET = 2'h0;
  // counter landmarks
  localparam logic [4:0] SCRL_CNT_HOLD = 5'h10;
  localparam logic [4:0] SCRL_CNT_ADJ = 5'h05;
  localparam logic [4:0] SCRL_CNT_LAST = 5'h1F;
  localparam logic [4:0] SCRL_CNT_DECIDE = 5'h02;
  // half-count positions (count * 2 + second half)
  localparam logic [5:0] SCRL_POS_MID15 = 6'h1F;
  localparam logic [5:0] SCRL_POS_MID16 = 6'h20;
  localparam logic [5:0] SCRL_POS_MID12 = 6'h19;
  localparam logic [5:0] SCRL_POS_MID19 = 6'h26;
  // status bit positions
  localparam int SCRL_ST_EN = 0;
  localparam int SCRL_ST_FM = 1;
  localparam int SCRL_ST_SEARCH = 2;
  localparam int SCRL_ST_SRC = 3;
  localparam int SCRL_ST_MISS1 = 4;
  localparam int SCRL_ST_MISS2 = 5;
  localparam int SCRL_ST_CNT = 8;

  typedef enum logic [1:0] {CORR_NONE, CORR_LONG, CORR_SHORT} scrl_corr_type;
  typedef enum {LOOP_OFF, LOOP_SEARCH, LOOP_RUN} scrl_state_type;

  // status bundle seen by software
  typedef struct packed {
    logic [4:0] count;
    logic miss2;
    logic miss1;
    logic src_pin;
    logic searching;
    logic fm;
    logic enabled;
  } scrl_status_type;
endpackage : scrl_pkg

// ---- rtl/scrl_loop.sv ----
// Purpose: digital clock recovery loop with APB register access
// Assumes: ref_clk 40 MHz; oversampling clock is a tick from a divider
// Notes: zero-wait APB slave; unmapped addresses answer with pslverr
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module scrl_loop (
  input wire logic ref_clk, // system clock
  input wire logic rst, // asynchronous reset, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic rx_data, // receive data pin
  output logic rx_clk, // recovered receive clock
  output logic tx_clk, // recovered transmit clock
  output scrl_pkg::scrl_status_type status, // loop state
  output logic [1:0] line_coding // line_coding_config field
);
  import scrl_pkg::*;

  // register state
  logic [15:0] div;
  logic [15:0] next_div;
  logic [1:0] coding;
  logic [1:0] next_coding;
  logic fm;
  logic next_fm;
  logic src_pin;
  logic next_src_pin;
  logic miss1;
  logic next_miss1;
  logic miss2;
  logic next_miss2;
  scrl_state_type state;
  scrl_state_type next_state;
  // loop state
  logic [15:0] div_cnt;
  logic [15:0] next_div_cnt;
  logic [4:0] count;
  logic [4:0] next_count;
  logic adj_done;
  logic next_adj_done;
  scrl_corr_type corr;
  scrl_corr_type next_corr;
  scrl_corr_type seen;
  scrl_corr_type next_seen;
  logic win_edge;
  logic next_win_edge;
  logic missed_last;
  logic next_missed_last;
  logic go_search;
  logic next_go_search;
  logic [2:0] sync;
  logic [2:0] next_sync;
  logic line;
  logic next_line;
  // helpers
  logic wr;
  logic rd_ok;
  logic [2:0] cmd;
  logic tick;
  logic second_half;
  logic edge_hit;
  logic [5:0] pos;
  logic set_miss1;
  logic set_miss2;

  // apb decode, zero-wait slave
  assign pready = 1'b1;
  assign wr = psel && penable && pwrite;
  assign cmd = (wr && paddr == SCRL_OFS_CMD) ? pwdata[SCRL_CMD_MSB:SCRL_CMD_LSB] : SCRL_CMD_NULL;
  assign rd_ok = (paddr == SCRL_OFS_CMD) || (paddr == SCRL_OFS_DIV)
    || (paddr == SCRL_OFS_STATUS) || (paddr == SCRL_OFS_CODING);
  assign pslverr = psel && penable && !rd_ok;

  // status view; reads have no side effects
  always_comb
  begin
    status.count = count;
    status.miss2 = miss2;
    status.miss1 = miss1;
    status.src_pin = src_pin;
    status.searching = (state != LOOP_RUN);
    status.fm = fm;
    status.enabled = (state != LOOP_OFF);
  end

  // read data mux
  always_comb
  begin
    prdata = 32'h0000_0000;
    if (psel && !pwrite)
    begin
      unique case (paddr)
        SCRL_OFS_DIV: prdata = {16'h0000, div};
        SCRL_OFS_STATUS: prdata = {19'h00000, status.count, 2'h0, status.miss2,
          status.miss1, status.src_pin, status.searching, status.fm, status.enabled};
        SCRL_OFS_CODING: prdata = {30'h0000_0000, coding};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  assign line_coding = coding;

  // input synchroniser; change accepted when stages two and three agree
  always_comb
  begin
    next_sync = {sync[1:0], rx_data};
    next_line = (sync[1] == sync[2]) ? sync[2] : line;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sync <= 3'h0;
      line <= 1'b0;
    end
    else
    begin
      sync <= next_sync;
      line <= next_line;
    end
  end

  // oversampling tick; divisor models the loop source clock rate
  assign tick = (div_cnt >= div - 16'h0001);
  assign second_half = (div_cnt >= {1'b0, div[15:1]});
  assign edge_hit = (next_line != line);
  assign pos = {count, second_half};

  // software registers, mode and flags
  always_comb
  begin
    next_div = div;
    next_coding = coding;
    next_fm = fm;
    next_src_pin = src_pin;
    next_miss1 = miss1;
    next_miss2 = miss2;
    if (wr && paddr == SCRL_OFS_DIV)
      next_div = (pwdata[15:0] < SCRL_DIV_MIN) ? SCRL_DIV_MIN : pwdata[15:0];
    if (wr && paddr == SCRL_OFS_CODING)
      next_coding = pwdata[1:0];
    unique case (cmd)
      SCRL_CMD_FM: next_fm = 1'b1;
      SCRL_CMD_NRZI: next_fm = 1'b0;
      SCRL_CMD_SRC_GEN: next_src_pin = 1'b0;
      SCRL_CMD_SRC_PIN: next_src_pin = 1'b1;
      SCRL_CMD_SEARCH, SCRL_CMD_CLR_MISS, SCRL_CMD_DISABLE:
      begin
        next_miss1 = 1'b0;
        next_miss2 = 1'b0;
      end
      default: ;
    endcase
    // a miss detected in the same cycle wins over any clear
    if (set_miss1)
      next_miss1 = 1'b1;
    if (set_miss2)
      next_miss2 = 1'b1;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      div <= SCRL_DIV_RESET;
      coding <= SCRL_CODING_RESET;
      fm <= 1'b0;
      src_pin <= 1'b1;
      miss1 <= 1'b0;
      miss2 <= 1'b0;
    end
    else
    begin
      div <= next_div;
      coding <= next_coding;
      fm <= next_fm;
      src_pin <= next_src_pin;
      miss1 <= next_miss1;
      miss2 <= next_miss2;
    end
  end

  // loop state, counter and phase correction
  always_comb
  begin
    next_state = state;
    next_div_cnt = tick ? 16'h0000 : div_cnt + 16'h0001;
    next_count = count;
    next_adj_done = adj_done;
    next_corr = corr;
    next_seen = seen;
    next_win_edge = win_edge;
    next_missed_last = missed_last;
    next_go_search = go_search;
    set_miss1 = 1'b0;
    set_miss2 = 1'b0;
    unique case (state)
      LOOP_OFF:
      begin
        next_count = SCRL_CNT_HOLD; // counter held while disabled
      end
      LOOP_SEARCH:
      begin
        next_count = SCRL_CNT_HOLD;
        if (edge_hit)
        begin
          // first edge marks a cell boundary between 15 and 16
          next_state = LOOP_RUN;
          next_div_cnt = 16'h0000;
          next_corr = CORR_NONE;
          next_seen = CORR_NONE;
          next_win_edge = 1'b1;
          next_missed_last = 1'b0;
          next_adj_done = 1'b0;
        end
      end
      LOOP_RUN:
      begin
        // classify an edge by the half-count in which it lands
        if (edge_hit)
        begin
          if (!fm)
          begin
            if (pos == SCRL_POS_MID15 || pos == SCRL_POS_MID16)
              next_seen = CORR_NONE;
            else if (pos > SCRL_POS_MID16)
              next_seen = CORR_LONG;
            else
              next_seen = CORR_SHORT;
          end
          else if (pos >= SCRL_POS_MID12 && pos <= SCRL_POS_MID19)
          begin
            next_win_edge = 1'b1;
            if (pos == SCRL_POS_MID15 || pos == SCRL_POS_MID16)
              next_seen = CORR_NONE;
            else if (pos > SCRL_POS_MID16)
              next_seen = CORR_LONG;
            else
              next_seen = CORR_SHORT;
          end
        end
        if (tick)
        begin
          next_count = count + 5'h01;
          // count five is repeated or skipped once per cycle
          if (count == SCRL_CNT_ADJ && corr == CORR_LONG && !adj_done)
          begin
            next_count = count;
            next_adj_done = 1'b1;
          end
          else if (count == SCRL_CNT_ADJ - 5'h01 && corr == CORR_SHORT && !adj_done)
          begin
            next_count = SCRL_CNT_ADJ + 5'h01;
            next_adj_done = 1'b1;
          end
          if (count == SCRL_CNT_LAST)
          begin
            // end of cycle: correction for the next cycle is fixed here
            next_corr = next_seen;
            next_adj_done = 1'b0;
            next_seen = CORR_NONE;
            next_win_edge = 1'b0;
            if (fm && !win_edge)
            begin
              next_corr = CORR_NONE;
              set_miss1 = 1'b1;
              next_missed_last = 1'b1;
              if (missed_last)
              begin
                set_miss2 = 1'b1;
                next_go_search = 1'b1;
              end
            end
            else
              next_missed_last = 1'b0;
          end
          // fall back to search at count two, where both clocks are low
          if (go_search && count == SCRL_CNT_DECIDE)
          begin
            next_state = LOOP_SEARCH;
            next_count = SCRL_CNT_HOLD;
            next_go_search = 1'b0;
          end
        end
      end
    endcase
    // commands override the sequencer
    if (cmd == SCRL_CMD_SEARCH)
    begin
      next_state = LOOP_SEARCH;
      next_count = SCRL_CNT_HOLD;
      next_go_search = 1'b0;
      next_missed_last = 1'b0;
    end
    else if (cmd == SCRL_CMD_DISABLE)
    begin
      next_state = LOOP_OFF;
      next_count = SCRL_CNT_HOLD;
      next_go_search = 1'b0;
      next_missed_last = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= LOOP_OFF;
      div_cnt <= 16'h0000;
      count <= SCRL_CNT_HOLD;
      adj_done <= 1'b0;
      corr <= CORR_NONE;
      seen <= CORR_NONE;
      win_edge <= 1'b0;
      missed_last <= 1'b0;
      go_search <= 1'b0;
    end
    else
    begin
      state <= next_state;
      div_cnt <= next_div_cnt;
      count <= next_count;
      adj_done <= next_adj_done;
      corr <= next_corr;
      seen <= next_seen;
      win_edge <= next_win_edge;
      missed_last <= next_missed_last;
      go_search <= next_go_search;
    end
  end

  // output decoders, registered; fm rx high at counts 4-11 and 20-27
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rx_clk <= 1'b1;
      tx_clk <= 1'b1;
    end
    else if (!next_fm)
    begin
      rx_clk <= next_count[4];
      tx_clk <= next_count[4];
    end
    else
    begin
      rx_clk <= (next_count[3:2] == 2'h1) || (next_count[3:2] == 2'h2);
      tx_clk <= next_count[3] && (next_state == LOOP_RUN);
    end
  end
endmodule : scrl_loop

// ---- testbench/scrl_loop_properties.sv ----
// Purpose: concurrent checks on the recovery loop ports
// Assumes: one clock domain, reset high puts the loop to rest
// Notes: attached to the loop by the bind at the foot of this file
`timescale 1ns/1ps
module scrl_loop_properties (
  input wire logic ref_clk, // system clock
  input wire logic rst, // async reset
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic rx_clk, // receive clock
  input wire logic tx_clk, // transmit clock
  input wire scrl_pkg::scrl_status_type status // loop state
);
  import scrl_pkg::*;
  logic cmd_wr; // command write taken
  logic [2:0] cmd; // command field
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // command decode
  assign cmd_wr = psel && penable && pwrite && paddr == SCRL_OFS_CMD;
  assign cmd = pwdata[SCRL_CMD_MSB:SCRL_CMD_LSB];
  // levels at rest and in search
  reset_state_a: assert property (
    $fell(rst) |-> !status.enabled && !status.fm && status.src_pin
      && status.count == SCRL_CNT_HOLD && rx_clk && tx_clk)
    else $error("bad state after reset");
  search_hold_a: assert property (
    status.enabled && status.searching ##1 status.enabled && status.searching
      |-> status.count == SCRL_CNT_HOLD)
    else $error("search count not held");
  nrzi_idle_a: assert property (
    status.searching && !status.fm ##1 status.searching && !status.fm |-> rx_clk && tx_clk)
    else $error("nrzi idle clocks not high");
  fm_idle_a: assert property (
    status.searching && status.fm ##1 status.searching && status.fm |-> !rx_clk && !tx_clk)
    else $error("fm idle clocks not low");
  // missed-edge flags
  nrzi_flags_a: assert property (
    !status.fm ##1 !status.fm |-> !$rose(status.miss1) && !$rose(status.miss2))
    else $error("miss flag set in nrzi");
  single_miss_a: assert property (
    $rose(status.miss1) |-> status.fm && status.enabled && !status.searching)
    else $error("single miss out of place");
  double_miss_a: assert property (
    $rose(status.miss2) |-> !status.searching ##[1:300] status.searching)
    else $error("no search after double miss");
  decide_point_a: assert property (
    $rose(status.searching) && status.enabled && status.miss2
      |-> $past(status.count) inside {5'h01, 5'h02} && !rx_clk && !tx_clk)
    else $error("search entered off count two");
  // command effects and apb answer
  clear_cmd_a: assert property (
    cmd_wr && cmd == SCRL_CMD_CLR_MISS && status.searching |=> !status.miss1 && !status.miss2)
    else $error("clear left a flag");
  search_cmd_a: assert property (
    cmd_wr && cmd == SCRL_CMD_SEARCH
      |=> status.enabled && status.searching && !status.miss1 && !status.miss2)
    else $error("search command not obeyed");
  disable_cmd_a: assert property (
    cmd_wr && cmd == SCRL_CMD_DISABLE |=> !status.enabled && !status.miss1 && !status.miss2)
    else $error("disable command not obeyed");
  mode_cmd_a: assert property (
    cmd_wr && cmd[2:1] == 2'h3 |=> status.fm == !$past(cmd[0]))
    else $error("mode command not obeyed");
  apb_answer_a: assert property (
    psel && penable |-> pready && (paddr <= SCRL_OFS_CODING || pslverr))
    else $error("apb answer wrong");
  // main scenarios reached
  cover property ($rose(status.miss2));
  cover property ($fell(status.searching) && status.fm);
  cover property ($fell(status.searching) && !status.fm);
endmodule : scrl_loop_properties
bind scrl_loop scrl_loop_properties u_props (.ref_clk(ref_clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .rx_clk(rx_clk), .tx_clk(tx_clk), .status(status));

// ---- testbench/scrl_line_model.sv ----
// Purpose: remote sender driving the receive data line
// Assumes: the bench sets the edge spacing in ref_clk cycles
// Notes: toggles on cell boundaries only, so the line carries clock edges
`timescale 1ns/1ps
module scrl_line_model (
  input wire logic ref_clk, // system clock
  input wire logic rst, // async reset
  input wire logic run, // send edges while high
  input wire logic [7:0] spacing, // cycles between edges
  output logic rx_data // serial line
);
  logic [7:0] cnt; // cycles since last edge
  logic [7:0] next_cnt; // next count
  logic next_rx_data; // next line level
  // edge spacing of spacing ref_clk cycles for any spacing from 1 up, lock pattern only
  always_comb
  begin
    next_cnt = run ? cnt + 8'h01 : 8'h00;
    next_rx_data = rx_data;
    if (run && next_cnt >= spacing)
    begin
      next_cnt = 8'h00;
      next_rx_data = !rx_data;
    end
  end
  // line state
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt <= 8'h00;
      rx_data <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      rx_data <= next_rx_data;
    end
  end
endmodule : scrl_line_model

// ---- testbench/scrl_loop_tb.sv ----
// Purpose: register and clock recovery tests for the loop
// Assumes: tick divisor left at 2, so one count is two ref_clk cycles
// Notes: a cycle of 32 counts is 64 ref_clk cycles
`timescale 1ns/1ps
module scrl_loop_tb;
  import scrl_pkg::*;
  logic ref_clk = 1'b0;
  logic rst, psel, penable, pwrite, run, rx_data, rx_clk, tx_clk, pready, pslverr;
  logic [7:0] paddr, spacing;
  logic [31:0] pwdata, prdata;
  logic [1:0] line_coding;
  scrl_status_type status;
  int n_fail = 0;
  int n_compared = 0;
  int hi, per, lag;
  logic [7:0] sp_tab [4] = '{8'h42, 8'h42, 8'h3E, 8'h40};
  logic run_tab [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
  logic [31:0] per_tab [4] = '{32'h42, 32'h40, 32'h3E, 32'h40};
  // clock, 25 ns period
  always #12.5 ref_clk = !ref_clk;
  scrl_loop u_dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_data(rx_data), .rx_clk(rx_clk), .tx_clk(tx_clk),
    .status(status), .line_coding(line_coding));
  scrl_line_model u_line (.ref_clk(ref_clk), .rst(rst), .run(run), .spacing(spacing),
    .rx_data(rx_data));
  // verdict and end of run
  task automatic complete_run;
    if (n_fail == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run
  // value comparison
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  // one apb transfer, held until pready is seen
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // only the watchdog ends a wait for the answer
    do
      @(posedge ref_clk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // read and compare data and error
  task automatic rd_check(input logic [7:0] a, input logic [31:0] exp, input logic err);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    check(q, exp);
    check({31'h0, e}, {31'h0, err});
  endtask : rd_check
  // register write, then let outputs settle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    repeat (3) @(negedge ref_clk);
  endtask : wr
  // loop command
  task automatic cmd(input logic [2:0] code);
    wr(SCRL_OFS_CMD, {24'h0, code, 5'h00});
  endtask : cmd
  // sender control at a rising edge
  task automatic line(input logic r, input logic [7:0] s);
    @(posedge ref_clk);
    run <= r;
    spacing <= s;
  endtask : line
  // rx_clk high time and period, then tx_clk rise delay
  task automatic measure(output int h, output int p, output int l);
    int n;
    n = 0;
    while (rx_clk !== 1'b0 && n < 500)
    begin
      @(posedge ref_clk);
      n++;
    end
    while (rx_clk !== 1'b1 && n < 1000)
    begin
      @(posedge ref_clk);
      n++;
    end
    h = 0;
    while (rx_clk === 1'b1 && h < 500)
    begin
      @(posedge ref_clk);
      h++;
    end
    p = h;
    while (rx_clk === 1'b0 && p < 500)
    begin
      @(posedge ref_clk);
      p++;
    end
    l = 0;
    while (tx_clk !== 1'b1 && l < 100)
    begin
      @(posedge ref_clk);
      l++;
    end
  endtask : measure
  // watchdog
  initial
  begin
    #(25 * 40000);
    n_fail++;
    complete_run();
  end
  // test sequence
  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    run = 1'b0;
    spacing = 8'h40;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    rd_check(SCRL_OFS_STATUS, 32'h100C, 1'b0);
    rd_check(SCRL_OFS_CMD, 32'h0, 1'b0);
    rd_check(8'h10, 32'h0, 1'b1);
    wr(SCRL_OFS_DIV, 32'h1);
    rd_check(SCRL_OFS_DIV, 32'h2, 1'b0);
    wr(SCRL_OFS_CODING, 32'h3);
    check({30'h0, line_coding}, 32'h3);
    rd_check(SCRL_OFS_CODING, 32'h3, 1'b0);
    wr(SCRL_OFS_CODING, 32'h0);
    check({30'h0, line_coding}, 32'h0);
    cmd(SCRL_CMD_SRC_GEN);
    rd_check(SCRL_OFS_STATUS, 32'h1004, 1'b0);
    cmd(SCRL_CMD_SRC_PIN);
    cmd(SCRL_CMD_FM);
    check({30'h0, rx_clk, tx_clk}, 32'h0);
    cmd(SCRL_CMD_NRZI);
    check({30'h0, rx_clk, tx_clk}, 32'h3);
    // nrzi lock on late, absent, early and centred edges
    line(1'b1, 8'h42);
    cmd(SCRL_CMD_SEARCH);
    for (int i = 0; i < 4; i++)
    begin
      line(run_tab[i], sp_tab[i]);
      repeat (2000) @(posedge ref_clk);
      measure(hi, per, lag);
      check(hi, 32'h20);
      check(per, per_tab[i]);
      if (i == 1)
      begin
        cmd(SCRL_CMD_SEARCH);
        rd_check(SCRL_OFS_STATUS, 32'h100D, 1'b0);
      end
    end
    // fm lock, then lost edges
    cmd(SCRL_CMD_DISABLE);
    cmd(SCRL_CMD_FM);
    line(1'b1, 8'h20);
    cmd(SCRL_CMD_SEARCH);
    repeat (1500) @(posedge ref_clk);
    measure(hi, per, lag);
    check(hi, 32'h10);
    check(per, 32'h20);
    check(lag, 32'h8);
    line(1'b0, 8'h20);
    repeat (400) @(posedge ref_clk);
    rd_check(SCRL_OFS_STATUS, 32'h103F, 1'b0);
    rd_check(SCRL_OFS_STATUS, 32'h103F, 1'b0);
    cmd(SCRL_CMD_CLR_MISS);
    rd_check(SCRL_OFS_STATUS, 32'h100F, 1'b0);
    cmd(SCRL_CMD_DISABLE);
    cmd(SCRL_CMD_NULL);
    rd_check(SCRL_OFS_STATUS, 32'h100E, 1'b0);
    complete_run();
  end
endmodule : scrl_loop_tb
